// ---- src/dsfb_bank.sv ----
// Purpose: Status, soft control and alarm/warning flag bytes
// Assumes: Measurements arrive on sys_clk_i; register port on link_clk_i
// Notes:   Flags cross to the link by a toggle handshake
`timescale 1ns/100ps
`include "dsfb_consts.svh"

module dsfb_bank
  import dsfb_pkg::*;
(
  input  wire logic        sys_clk_i,
  input  wire logic        rstn_i,
  input  wire logic        link_clk_i,
  input  wire logic        tx_disable_pin_i,
  input  wire logic        rx_signal_lost_i,
  input  wire logic        meas_valid_i,
  input  wire logic [15:0] meas_temp_i,
  input  wire logic [15:0] meas_vcc_i,
  input  wire logic [15:0] meas_bias_i,
  input  wire logic [15:0] meas_txp_i,
  input  wire logic [15:0] meas_rxp_i,
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic        reg_wr_i,
  input  wire logic [7:0]  reg_wdata_i,
  input  wire logic        reg_rd_i,
  output logic [7:0]       reg_rdata_o,
  output logic             tx_disable_o
);

  // =====================================================================
  // Declarations
  logic           hw_txdis_s;
  logic           rx_lost_s;
  logic           soft_txdis_s;
  logic           ack_s;
  logic           req_s;
  logic           ready_n_r;
  logic           req_r;
  logic           ack_r;
  logic           soft_txdis_r;
  dsfb_hs_state_t hs_state_r;
  dsfb_snap_t     snap_r;
  dsfb_snap_t     snap_nxt;
  dsfb_snap_t     link_snap_r;
  logic [7:0]     alarm_a;
  logic [1:0]     alarm_b;
  logic [7:0]     warn_a;
  logic [1:0]     warn_b;
  logic [7:0]     status_byte;
  logic [7:0]     rdata_nxt;

  dsfb_cmp_if temp_if ();
  dsfb_cmp_if vcc_if ();
  dsfb_cmp_if bias_if ();
  dsfb_cmp_if txp_if ();
  dsfb_cmp_if rxp_if ();

  // =====================================================================
  // Pin and cross-domain synchronisers (sys side)
  dsfb_sync u_sync_hw_txdis (
    .clk_i  (sys_clk_i),
    .rstn_i (rstn_i),
    .d_i    (tx_disable_pin_i),
    .q_o    (hw_txdis_s)
  );

  dsfb_sync u_sync_rx_lost (
    .clk_i  (sys_clk_i),
    .rstn_i (rstn_i),
    .d_i    (rx_signal_lost_i),
    .q_o    (rx_lost_s)
  );

  dsfb_sync u_sync_soft (
    .clk_i  (sys_clk_i),
    .rstn_i (rstn_i),
    .d_i    (soft_txdis_r),
    .q_o    (soft_txdis_s)
  );

  dsfb_sync u_sync_ack (
    .clk_i  (sys_clk_i),
    .rstn_i (rstn_i),
    .d_i    (ack_r),
    .q_o    (ack_s)
  );

  // =====================================================================
  // Transmit disable
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tx_disable_o <= 1'b0;
    end else begin
      tx_disable_o <= soft_txdis_s | hw_txdis_s;
    end
  end

  // =====================================================================
  // Data ready
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ready_n_r <= `DSFB_RST_READY_N;
    end else if (meas_valid_i) begin
      ready_n_r <= 1'b0;
    end
  end

  // =====================================================================
  // Threshold checkers
  assign temp_if.meas = meas_temp_i;
  assign temp_if.upd  = meas_valid_i;
  assign vcc_if.meas  = meas_vcc_i;
  assign vcc_if.upd   = meas_valid_i;
  assign bias_if.meas = meas_bias_i;
  assign bias_if.upd  = meas_valid_i;
  assign txp_if.meas  = meas_txp_i;
  assign txp_if.upd   = meas_valid_i;
  assign rxp_if.meas  = meas_rxp_i;
  assign rxp_if.upd   = meas_valid_i;

  // Temperature, signed compare
  dsfb_cmp #(
    .HI_ALM (`DSFB_TEMP_HI_ALM),
    .LO_ALM (`DSFB_TEMP_LO_ALM),
    .HI_WRN (`DSFB_TEMP_HI_WRN),
    .LO_WRN (`DSFB_TEMP_LO_WRN),
    .SIGNED (1'b1)
  ) u_cmp_temp (
    .clk_i  (sys_clk_i),
    .rstn_i (rstn_i),
    .port   (temp_if)
  );

  // Supply voltage
  dsfb_cmp #(
    .HI_ALM (`DSFB_VCC_HI_ALM),
    .LO_ALM (`DSFB_VCC_LO_ALM),
    .HI_WRN (`DSFB_VCC_HI_WRN),
    .LO_WRN (`DSFB_VCC_LO_WRN),
    .SIGNED (1'b0)
  ) u_cmp_vcc (
    .clk_i  (sys_clk_i),
    .rstn_i (rstn_i),
    .port   (vcc_if)
  );

  // Bias current
  dsfb_cmp #(
    .HI_ALM (`DSFB_BIAS_HI_ALM),
    .LO_ALM (`DSFB_BIAS_LO_ALM),
    .HI_WRN (`DSFB_BIAS_HI_WRN),
    .LO_WRN (`DSFB_BIAS_LO_WRN),
    .SIGNED (1'b0)
  ) u_cmp_bias (
    .clk_i  (sys_clk_i),
    .rstn_i (rstn_i),
    .port   (bias_if)
  );

  // Transmit power
  dsfb_cmp #(
    .HI_ALM (`DSFB_TXP_HI_ALM),
    .LO_ALM (`DSFB_TXP_LO_ALM),
    .HI_WRN (`DSFB_TXP_HI_WRN),
    .LO_WRN (`DSFB_TXP_LO_WRN),
    .SIGNED (1'b0)
  ) u_cmp_txp (
    .clk_i  (sys_clk_i),
    .rstn_i (rstn_i),
    .port   (txp_if)
  );

  // Receive power, unsigned compare
  dsfb_cmp #(
    .HI_ALM (`DSFB_RXP_HI_ALM),
    .LO_ALM (`DSFB_RXP_LO_ALM),
    .HI_WRN (`DSFB_RXP_HI_WRN),
    .LO_WRN (`DSFB_RXP_LO_WRN),
    .SIGNED (1'b0)
  ) u_cmp_rxp (
    .clk_i  (sys_clk_i),
    .rstn_i (rstn_i),
    .port   (rxp_if)
  );

  // =====================================================================
  // Flag byte assembly
  assign alarm_a = {temp_if.flags[3], temp_if.flags[2],
                    vcc_if.flags[3],  vcc_if.flags[2],
                    bias_if.flags[3], bias_if.flags[2],
                    txp_if.flags[3],  txp_if.flags[2]};
  assign alarm_b = {rxp_if.flags[3],  rxp_if.flags[2]};
  assign warn_a  = {temp_if.flags[1], temp_if.flags[0],
                    vcc_if.flags[1],  vcc_if.flags[0],
                    bias_if.flags[1], bias_if.flags[0],
                    txp_if.flags[1],  txp_if.flags[0]};
  assign warn_b  = {rxp_if.flags[1],  rxp_if.flags[0]};

  always_comb begin
    snap_nxt.txdis_state = tx_disable_o;
    snap_nxt.rx_lost     = rx_lost_s;
    snap_nxt.ready_n     = ready_n_r;
    snap_nxt.alarm_a     = alarm_a;
    snap_nxt.alarm_b     = alarm_b;
    snap_nxt.warn_a      = warn_a;
    snap_nxt.warn_b      = warn_b;
  end

  // =====================================================================
  // Snapshot handshake, sys side
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      hs_state_r <= DSFB_HS_IDLE;
      req_r      <= 1'b0;
      snap_r     <= '0;
    end else begin
      unique case (hs_state_r)
        DSFB_HS_IDLE: begin
          snap_r     <= snap_nxt;
          req_r      <= ~req_r;
          hs_state_r <= DSFB_HS_WAIT;
        end
        DSFB_HS_WAIT: begin
          if (ack_s == req_r) begin
            hs_state_r <= DSFB_HS_IDLE;
          end
        end
        default: begin
          hs_state_r <= DSFB_HS_IDLE;
        end
      endcase
    end
  end

  // =====================================================================
  // Snapshot handshake, link side
  dsfb_sync u_sync_req (
    .clk_i  (link_clk_i),
    .rstn_i (rstn_i),
    .d_i    (req_r),
    .q_o    (req_s)
  );

  always_ff @(posedge link_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ack_r       <= 1'b0;
      link_snap_r <= '0;
      link_snap_r.ready_n <= `DSFB_RST_READY_N;
    end else if (req_s != ack_r) begin
      link_snap_r <= snap_r; // stable while request is open
      ack_r       <= req_s;
    end
  end

  // =====================================================================
  // Soft transmit disable register
  always_ff @(posedge link_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      soft_txdis_r <= `DSFB_RST_SOFT_TXDIS;
    end else if (reg_wr_i && reg_addr_i == `DSFB_ADDR_STATUS) begin
      soft_txdis_r <= reg_wdata_i[`DSFB_BIT_SOFT_TXDIS];
    end
  end

  // =====================================================================
  // Read path
  always_comb begin
    status_byte = `DSFB_RST_BYTE;
    status_byte[`DSFB_BIT_TXDIS_STATE] = link_snap_r.txdis_state;
    status_byte[`DSFB_BIT_SOFT_TXDIS]  = soft_txdis_r;
    status_byte[`DSFB_BIT_RX_LOST]     = link_snap_r.rx_lost;
    status_byte[`DSFB_BIT_READY_N]     = link_snap_r.ready_n;
  end

  always_comb begin
    unique case (reg_addr_i)
      `DSFB_ADDR_STATUS:  rdata_nxt = status_byte;
      `DSFB_ADDR_ALARM_A: rdata_nxt = link_snap_r.alarm_a;
      `DSFB_ADDR_ALARM_B: rdata_nxt = {link_snap_r.alarm_b, `DSFB_RSVD_BITS};
      `DSFB_ADDR_WARN_A:  rdata_nxt = link_snap_r.warn_a;
      `DSFB_ADDR_WARN_B:  rdata_nxt = {link_snap_r.warn_b, `DSFB_RSVD_BITS};
      default:            rdata_nxt = `DSFB_RST_BYTE;
    endcase
  end

  always_ff @(posedge link_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      reg_rdata_o <= `DSFB_RST_BYTE;
    end else if (reg_rd_i) begin
      reg_rdata_o <= rdata_nxt;
    end
  end

endmodule // dsfb_bank

// ---- include/dsfb_consts.svh ----
// Purpose: Named constants of the diagnostic status and flag bank
// Assumes: Included by bare name
// Notes:   Definitions only
`ifndef DSFB_CONSTS_SVH
`define DSFB_CONSTS_SVH

// =====================================================================
// Register offsets
`define DSFB_ADDR_STATUS    8'h6e
`define DSFB_ADDR_ALARM_A   8'h70
`define DSFB_ADDR_ALARM_B   8'h71
`define DSFB_ADDR_WARN_A    8'h74
`define DSFB_ADDR_WARN_B    8'h75

// =====================================================================
// Status byte fields and reset values
`define DSFB_BIT_TXDIS_STATE 7
`define DSFB_BIT_SOFT_TXDIS  6
`define DSFB_BIT_RX_LOST     1
`define DSFB_BIT_READY_N     0
`define DSFB_RST_SOFT_TXDIS  1'b0
`define DSFB_RST_READY_N     1'b1
`define DSFB_RST_BYTE        8'h00
`define DSFB_RSVD_BITS       6'h00

// =====================================================================
// Thresholds: temperature, 1/256 degC signed (85, -40, 80, -35 degC)
`define DSFB_TEMP_HI_ALM 16'h5500
`define DSFB_TEMP_LO_ALM 16'hd800
`define DSFB_TEMP_HI_WRN 16'h5000
`define DSFB_TEMP_LO_WRN 16'hdd00
// Supply, 100 uV steps (3.6, 3.0, 3.5, 3.1 V)
`define DSFB_VCC_HI_ALM  16'h8ca0
`define DSFB_VCC_LO_ALM  16'h7530
`define DSFB_VCC_HI_WRN  16'h88b8
`define DSFB_VCC_LO_WRN  16'h7918
// Bias, 2 uA steps (120, 10, 110, 15 mA)
`define DSFB_BIAS_HI_ALM 16'hea60
`define DSFB_BIAS_LO_ALM 16'h1388
`define DSFB_BIAS_HI_WRN 16'hd6d8
`define DSFB_BIAS_LO_WRN 16'h1d4c
// Transmit power, 0.1 uW steps (-11, -23, -12, -22 dBm)
`define DSFB_TXP_HI_ALM  16'h031a
`define DSFB_TXP_LO_ALM  16'h0032
`define DSFB_TXP_HI_WRN  16'h0277
`define DSFB_TXP_LO_WRN  16'h003f
// Receive power, 0.1 uW steps (-11, -33, -12, -32 dBm)
`define DSFB_RXP_HI_ALM  16'h031a
`define DSFB_RXP_LO_ALM  16'h0005
`define DSFB_RXP_HI_WRN  16'h0277
`define DSFB_RXP_LO_WRN  16'h0006

`endif

// ---- include/dsfb_pkg.sv ----
// Purpose: Types of the diagnostic status and flag bank
// Assumes: Constants come from dsfb_consts.svh
// Notes:   None
package dsfb_pkg;
  // Snapshot handshake states
  typedef enum logic [1:0] {
    DSFB_HS_IDLE = 2'b01,
    DSFB_HS_WAIT = 2'b10
  } dsfb_hs_state_t;

  // Status and flags passed to the link side
  typedef struct packed {
    logic       txdis_state;
    logic       rx_lost;
    logic       ready_n;
    logic [7:0] alarm_a;
    logic [1:0] alarm_b;
    logic [7:0] warn_a;
    logic [1:0] warn_b;
  } dsfb_snap_t;
endpackage

// ---- include/dsfb_cmp_if.sv ----
// Purpose: Carrier between the bank and one threshold checker
// Assumes: Same clock on both ends
// Notes:   flags = {hi alarm, lo alarm, hi warning, lo warning}
`timescale 1ns/100ps
interface dsfb_cmp_if;
  logic [15:0] meas;
  logic        upd;
  logic [3:0]  flags;

  modport bank (output meas, output upd, input flags);
  modport cmp  (input meas, input upd, output flags);
endinterface

// ---- src/dsfb_sync.sv ----
// Purpose: Three-stage synchroniser with agreement filter
// Assumes: d_i from another domain
// Notes:   Output moves once stages two and three agree
`timescale 1ns/100ps
module dsfb_sync (
  input  wire logic clk_i,
  input  wire logic rstn_i,
  input  wire logic d_i,
  output logic      q_o
);
  logic s1_r;
  logic s2_r;
  logic s3_r;

  // =====================================================================
  // Stages
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      q_o  <= 1'b0;
    end else begin
      s1_r <= d_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        q_o <= s3_r;
      end
    end
  end
endmodule // dsfb_sync

// ---- src/dsfb_cmp.sv ----
// Purpose: Checks one measurement against four thresholds
// Assumes: upd marks a fresh measurement
// Notes:   Flags follow each update and clear with their cause
`timescale 1ns/100ps
module dsfb_cmp #(
  parameter logic [15:0] HI_ALM = 16'h0000,
  parameter logic [15:0] LO_ALM = 16'h0000,
  parameter logic [15:0] HI_WRN = 16'h0000,
  parameter logic [15:0] LO_WRN = 16'h0000,
  parameter bit          SIGNED = 1'b0
) (
  input  wire logic clk_i,
  input  wire logic rstn_i,
  dsfb_cmp_if.cmp   port
);
  logic [3:0] flags_nxt;

  // =====================================================================
  // Compare
  always_comb begin
    if (SIGNED) begin
      flags_nxt[3] = $signed(port.meas) > $signed(HI_ALM);
      flags_nxt[2] = $signed(port.meas) < $signed(LO_ALM);
      flags_nxt[1] = $signed(port.meas) > $signed(HI_WRN);
      flags_nxt[0] = $signed(port.meas) < $signed(LO_WRN);
    end else begin
      flags_nxt[3] = port.meas > HI_ALM;
      flags_nxt[2] = port.meas < LO_ALM;
      flags_nxt[1] = port.meas > HI_WRN;
      flags_nxt[0] = port.meas < LO_WRN;
    end
  end

  // =====================================================================
  // Flag hold
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      port.flags <= 4'h0;
    end else if (port.upd) begin
      port.flags <= flags_nxt;
    end
  end
endmodule // dsfb_cmp

// ---- tb/dsfb_bank_props.sv ----
// Purpose: Port assertions for the flag bank
// Assumes: Bound to dsfb_bank
// Notes:   Link checks allow one handshake round
`timescale 1ns/100ps
`include "dsfb_consts.svh"
module dsfb_bank_props (
  input  wire logic       sys_clk_i,
  input  wire logic       rstn_i,
  input  wire logic       link_clk_i,
  input  wire logic       tx_disable_pin_i,
  input  wire logic       rx_signal_lost_i,
  input  wire logic [7:0] reg_addr_i,
  input  wire logic       reg_wr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_rd_i,
  input  wire logic [7:0] reg_rdata_o,
  input  wire logic       tx_disable_o
);
  // ==============
  // Helpers
  logic       soft_r;
  logic [4:0] rx_cnt_r;
  logic [4:0] tx_cnt_r;

  always_ff @(posedge link_clk_i or negedge rstn_i) begin
    if (!rstn_i)
      soft_r <= 1'b0;
    else if (reg_wr_i && reg_addr_i == `DSFB_ADDR_STATUS)
      soft_r <= reg_wdata_i[6];
  end

  always_ff @(posedge link_clk_i or negedge rstn_i) begin
    if (!rstn_i)
      rx_cnt_r <= 5'h00;
    else if ($changed(rx_signal_lost_i))
      rx_cnt_r <= 5'h00;
    else if (rx_cnt_r != 5'h1f)
      rx_cnt_r <= rx_cnt_r + 5'h01;
  end

  always_ff @(posedge link_clk_i or negedge rstn_i) begin
    if (!rstn_i)
      tx_cnt_r <= 5'h00;
    else if ($changed(tx_disable_pin_i))
      tx_cnt_r <= 5'h00;
    else if (tx_cnt_r != 5'h1f)
      tx_cnt_r <= tx_cnt_r + 5'h01;
  end

  sequence rd_stat;
    reg_rd_i && reg_addr_i == `DSFB_ADDR_STATUS;
  endsequence
  sequence rd_unmapped;
    reg_rd_i && !(reg_addr_i inside {8'h6e, 8'h70, 8'h71, 8'h74, 8'h75});
  endsequence
  sequence pin_held;
    tx_disable_pin_i [*8];
  endsequence

  // ==============
  // Assertions
  AST_UNMAPPED_ZERO: assert property (@(posedge link_clk_i) disable iff (!rstn_i)
    rd_unmapped |=> reg_rdata_o == 8'h00) else $error("unmapped read not zero");
  AST_STATUS_RSVD: assert property (@(posedge link_clk_i) disable iff (!rstn_i)
    rd_stat |=> reg_rdata_o[5:2] == 4'h0) else $error("status reserved bits set");
  AST_RXP_ALM_RSVD: assert property (@(posedge link_clk_i) disable iff (!rstn_i)
    reg_rd_i && reg_addr_i == 8'h71 |=> reg_rdata_o[5:0] == 6'h00)
    else $error("rx alarm reserved bits set");
  AST_RXP_WRN_RSVD: assert property (@(posedge link_clk_i) disable iff (!rstn_i)
    reg_rd_i && reg_addr_i == 8'h75 |=> reg_rdata_o[5:0] == 6'h00)
    else $error("rx warning reserved bits set");
  AST_SOFT_READBACK: assert property (@(posedge link_clk_i) disable iff (!rstn_i)
    rd_stat |=> reg_rdata_o[6] == $past(soft_r)) else $error("soft bit readback wrong");
  AST_RX_LOST_BIT: assert property (@(posedge link_clk_i) disable iff (!rstn_i)
    rd_stat and rx_cnt_r >= 5'd24 |=> reg_rdata_o[1] == $past(rx_signal_lost_i))
    else $error("rx lost bit wrong");
  AST_TXDIS_BIT: assert property (@(posedge link_clk_i) disable iff (!rstn_i)
    rd_stat and tx_cnt_r >= 5'd24 && tx_disable_pin_i |=> reg_rdata_o[7])
    else $error("disable state bit low");
  AST_TXDIS_PIN: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    pin_held |-> tx_disable_o) else $error("pin disable not applied");
endmodule // dsfb_bank_props

bind dsfb_bank dsfb_bank_props i_dsfb_bank_props (.sys_clk_i, .rstn_i, .link_clk_i,
  .tx_disable_pin_i, .rx_signal_lost_i, .reg_addr_i, .reg_wr_i, .reg_wdata_i,
  .reg_rd_i, .reg_rdata_o, .tx_disable_o);

// ---- tb/dsfb_host_model.sv ----
// Purpose: Host controller model on the register port
// Assumes: Strobes launched on link clock edges
// Notes:   Idle address and data show inverted last values
`timescale 1ns/100ps
module dsfb_host_model (
  input  wire logic       link_clk_i,
  output logic [7:0]      reg_addr_o,
  output logic            reg_wr_o,
  output logic [7:0]      reg_wdata_o,
  output logic            reg_rd_o,
  input  wire logic [7:0] reg_rdata_i
);
  initial begin
    reg_addr_o  = 8'h00;
    reg_wr_o    = 1'b0;
    reg_wdata_o = 8'h00;
    reg_rd_o    = 1'b0;
  end

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge link_clk_i);
    reg_addr_o  <= a;
    reg_wdata_o <= d;
    reg_wr_o    <= 1'b1;
    @(posedge link_clk_i);
    reg_wr_o    <= 1'b0;
    reg_addr_o  <= ~a;
    reg_wdata_o <= ~d;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge link_clk_i);
    reg_addr_o <= a;
    reg_rd_o   <= 1'b1;
    @(posedge link_clk_i);
    reg_rd_o   <= 1'b0;
    reg_addr_o <= ~a;
    #1 d = reg_rdata_i;
  endtask
endmodule // dsfb_host_model

// ---- tb/tb.sv ----
// Purpose: Self-checking bench for the flag bank
// Assumes: Host model drives the register port
// Notes:   Waits of 30 link cycles cover the handshake
`timescale 1ns/100ps
module tb;
  logic        sys_clk_i;
  logic        link_clk_i;
  logic        rstn_i;
  logic        tx_pin;
  logic        rx_pin;
  logic        meas_valid;
  logic [15:0] meas [5];
  logic [7:0]  reg_addr_i;
  logic        reg_wr_i;
  logic [7:0]  reg_wdata_i;
  logic        reg_rd_i;
  logic [7:0]  reg_rdata_o;
  logic        tx_dis;
  logic [7:0]  d;
  int          bad_count;
  int          n_tests;
  int          cyc;
  // Columns: temp, vcc, bias, txp, rxp
  logic [15:0] vec [6][5] = '{
    '{16'h1900, 16'h80e8, 16'h4e20, 16'h00c8, 16'h00c8},
    '{16'h5501, 16'h8ca1, 16'hea61, 16'h031b, 16'h031b},
    '{16'hd7ff, 16'h752f, 16'h1387, 16'h0031, 16'h0004},
    '{16'h5500, 16'h8ca0, 16'hea60, 16'h031a, 16'h031a},
    '{16'hd800, 16'h7530, 16'h1388, 16'h0032, 16'h0005},
    '{16'h5000, 16'h88b8, 16'hd6d8, 16'h0277, 16'h0277}};
  // Expected bytes 0x70, 0x71, 0x74, 0x75
  logic [31:0] expf [6] = '{32'h00000000, 32'haa80aa80, 32'h55405540,
                            32'h0000aa80, 32'h00005540, 32'h00000000};

  dsfb_bank i_dsfb_bank (.sys_clk_i, .rstn_i, .link_clk_i,
    .tx_disable_pin_i(tx_pin), .rx_signal_lost_i(rx_pin), .meas_valid_i(meas_valid),
    .meas_temp_i(meas[0]), .meas_vcc_i(meas[1]), .meas_bias_i(meas[2]),
    .meas_txp_i(meas[3]), .meas_rxp_i(meas[4]), .reg_addr_i, .reg_wr_i,
    .reg_wdata_i, .reg_rd_i, .reg_rdata_o, .tx_disable_o(tx_dis));

  dsfb_host_model i_dsfb_host_model (.link_clk_i, .reg_addr_o(reg_addr_i),
    .reg_wr_o(reg_wr_i), .reg_wdata_o(reg_wdata_i), .reg_rd_o(reg_rd_i),
    .reg_rdata_i(reg_rdata_o));

  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  initial begin
    link_clk_i = 1'b0;
    #3.3;
    forever #16 link_clk_i = ~link_clk_i;
  end

  // ==============
  // Tasks
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [7:0] e);
    logic [7:0] g;
    i_dsfb_host_model.rd_reg(a, g);
    chk(nm, e, g);
  endtask

  task automatic settle;
    repeat (30) @(posedge link_clk_i);
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      bad_count++;
      complete_run;
    end
  end

  // ==============
  // Tests
  initial begin
    rstn_i = 1'b0;
    tx_pin = 1'b0;
    rx_pin = 1'b0;
    meas_valid = 1'b0;
    meas = '{5{16'h0000}};
    bad_count = 0;
    n_tests = 0;
    cyc = 0;
    repeat (4) @(posedge link_clk_i);
    @(posedge sys_clk_i);
    rstn_i <= 1'b1;
    settle();
    rd_chk("status", 8'h6e, 8'h01);
    rd_chk("unmapped", 8'h72, 8'h00);
    i_dsfb_host_model.wr_reg(8'h70, 8'hff);
    rd_chk("alarm_a ro", 8'h70, 8'h00);
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      @(posedge sys_clk_i);
      for (int k = 0; k < 5; k++)
        meas[k] <= vec[i][k];
      meas_valid <= 1'b1;
      @(posedge sys_clk_i);
      meas_valid <= 1'b0;
      settle();
      rd_chk("alarm_a", 8'h70, expf[i][31:24]);
      rd_chk("alarm_b", 8'h71, expf[i][23:16]);
      rd_chk("warn_a", 8'h74, expf[i][15:8]);
      rd_chk("warn_b", 8'h75, expf[i][7:0]);
    end
    rd_chk("status", 8'h6e, 8'h00);
    $display("test flags done");
    i_dsfb_host_model.wr_reg(8'h6e, 8'hff);
    i_dsfb_host_model.rd_reg(8'h6e, d);
    chk("soft", 8'h40, d & 8'h7f);
    settle();
    chk("tx_dis", 8'h01, {7'h00, tx_dis});
    rd_chk("status", 8'h6e, 8'hc0);
    i_dsfb_host_model.wr_reg(8'h6e, 8'h00);
    settle();
    chk("tx_dis", 8'h00, {7'h00, tx_dis});
    rd_chk("status", 8'h6e, 8'h00);
    $display("test soft done");
    @(posedge sys_clk_i);
    tx_pin <= 1'b1;
    rx_pin <= 1'b1;
    settle();
    chk("tx_dis", 8'h01, {7'h00, tx_dis});
    rd_chk("status", 8'h6e, 8'h82);
    @(posedge sys_clk_i);
    tx_pin <= 1'b0;
    rx_pin <= 1'b0;
    settle();
    rd_chk("status", 8'h6e, 8'h00);
    $display("test pins done");
    complete_run();
  end
endmodule // tb
